// ==== verilog/fpor_top.sv ====
/*
 * Flow pulse generator with pending queue, routed with alarm, totalizer,
 * diagnostic and manual sources onto two isolated outputs; AXI4-Lite
 * registers and one level interrupt.
 * Assumes flow, alarm, totalizer and diagnostic inputs come from logic
 * on sys_clk, and that the bus master keeps AXI4-Lite signalling.
 */
`timescale 1ns/1ps
`include "fpor_defines.svh"

// Notes on behaviour
// - Pulses come from the flow rate alone, never from the totalizers.
// - No pulse credit accrues while flow is below the start threshold.
// - One pulse is owed per units-per-pulse of accumulated quantity.
// - Each pulse stays high for the on-time, held within 10 to 6553 ms.
// - Owed pulses wait in a queue and drain once the output is free.
// - The pulse reaches an output only when that output selects pulse.
// - Two outputs exist, each with its own nine-way action selector.
// - A disabled output follows nothing and stays low.
// - Low, high and in-band alarm choices follow their conditions.
// - Totalizer choices drive the output from each totalizer limit flag.
// - The diagnostic choice is high while any diagnostic event is active.
// - The manual choice holds the output high until it is disabled.
// - Both selectors come out of reset disabled.
// - Totalizer one flags when its reading reaches its action volume.
// - Totalizer two counting down flags when its reading reaches zero.
module fpor_top #(
	parameter int ADDR_W    = 8,
	parameter int FLOW_W    = 16,
	parameter int Q_W       = 16,
	parameter int DIAG_N    = 8,
	parameter int MS_CYCLES = `FPOR_MS_NS / `FPOR_CLK_NS
) (
	// Clock, reset, enable
	input  wire logic              sys_clk,
	input  wire logic              reset_n,
	input  wire logic              clk_en,
	// AXI4-Lite write
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Measurement and event sources
	input  wire logic [FLOW_W-1:0] flow_rate,
	input  wire logic [9:0]        flow_permille,
	input  wire logic              alarm_low,
	input  wire logic              alarm_high,
	input  wire logic [31:0]       tot1_value,
	input  wire logic [31:0]       tot2_value,
	input  wire logic [DIAG_N-1:0] diag_events,
	// Isolated outputs and interrupt
	output logic [1:0]             iso_out,
	output logic                   irq
);
	import fpor_pkg::*;

	generate
		if (ADDR_W < 8 || FLOW_W < 1 || FLOW_W > 32 || Q_W < 2 ||
		    Q_W > 16 || DIAG_N < 1) begin : g_bad
			$error("fpor_top: parameter out of range");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	logic [7:0]            awa_q, awa_d, ara;
	logic                  awh_q, awh_d, wh_q, wh_d;
	logic [31:0]           wd_q, wd_d;
	logic [3:0]            ws_q, ws_d;
	logic                  bv_q, bv_d, rv_q, rv_d;
	logic [1:0]            br_q, br_d, rr_q, rr_d;
	logic [31:0]           rd_q, rd_d;
	logic [31:0]           ctrl_q, ctrl_d, units_q, units_d;
	logic [31:0]           lim1_q, lim1_d, lim2_q, lim2_d;
	logic [`FPOR_START_W-1:0]  start_q, start_d;
	logic [`FPOR_ONTIME_W-1:0] ontime_q, ontime_d;
	logic [`FPOR_IRQ_N-1:0]    ist_q, ist_d, imsk_q, imsk_d, ev;
	logic                  do_wr, do_rd;
	logic [31:0]           status;

	function automatic logic [31:0] merge(input logic [31:0] old,
	                                      input logic [31:0] nw,
	                                      input logic [3:0]  st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	assign s_axi_awready = clk_en & ~awh_q & ~bv_q;
	assign s_axi_wready  = clk_en & ~wh_q & ~bv_q;
	assign s_axi_arready = clk_en & ~rv_q;
	assign s_axi_bvalid  = bv_q;
	assign s_axi_bresp   = br_q;
	assign s_axi_rvalid  = rv_q;
	assign s_axi_rresp   = rr_q;
	assign s_axi_rdata   = rd_q;
	assign do_wr = awh_q & wh_q & ~bv_q;
	assign do_rd = s_axi_arvalid & s_axi_arready;
	assign ara   = {s_axi_araddr[7:2], 2'b00};

	always_comb begin
		awa_d = awa_q; awh_d = awh_q; wd_d = wd_q; ws_d = ws_q;
		wh_d = wh_q; bv_d = bv_q; br_d = br_q;
		rv_d = rv_q; rr_d = rr_q; rd_d = rd_q;
		ctrl_d = ctrl_q; start_d = start_q; units_d = units_q;
		ontime_d = ontime_q; lim1_d = lim1_q; lim2_d = lim2_q;
		imsk_d = imsk_q;
		if (s_axi_awvalid && s_axi_awready) begin
			awa_d = {s_axi_awaddr[7:2], 2'b00};
			awh_d = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wd_d = s_axi_wdata;
			ws_d = s_axi_wstrb;
			wh_d = 1'b1;
		end
		if (do_wr) begin
			awh_d = 1'b0;
			wh_d  = 1'b0;
			bv_d  = 1'b1;
			br_d  = `FPOR_RESP_OKAY;
			case (awa_q)
			`FPOR_ADDR_CTRL:     ctrl_d  = merge(ctrl_q, wd_q, ws_q);
			`FPOR_ADDR_START:    start_d = `FPOR_START_W'(merge(
			                       32'(start_q), wd_q, ws_q));
			`FPOR_ADDR_UNITS:    units_d = merge(units_q, wd_q, ws_q);
			`FPOR_ADDR_ONTIME:   ontime_d = `FPOR_ONTIME_W'(merge(
			                       32'(ontime_q), wd_q, ws_q));
			`FPOR_ADDR_TOT1_LIM: lim1_d  = merge(lim1_q, wd_q, ws_q);
			`FPOR_ADDR_TOT2_LIM: lim2_d  = merge(lim2_q, wd_q, ws_q);
			`FPOR_ADDR_IRQ_MASK: imsk_d  = `FPOR_IRQ_N'(merge(
			                       32'(imsk_q), wd_q, ws_q));
			`FPOR_ADDR_STATUS, `FPOR_ADDR_IRQ_STAT: br_d = `FPOR_RESP_OKAY;
			default:             br_d    = `FPOR_RESP_DECERR;
			endcase
		end
		if (bv_q && s_axi_bready) begin
			bv_d = 1'b0;
		end
		if (rv_q && s_axi_rready) begin
			rv_d = 1'b0;
		end
		if (do_rd) begin
			rv_d = 1'b1;
			rr_d = `FPOR_RESP_OKAY;
			case (ara)
			`FPOR_ADDR_CTRL:     rd_d = ctrl_q;
			`FPOR_ADDR_START:    rd_d = 32'(start_q);
			`FPOR_ADDR_UNITS:    rd_d = units_q;
			`FPOR_ADDR_ONTIME:   rd_d = 32'(ontime_q);
			`FPOR_ADDR_TOT1_LIM: rd_d = lim1_q;
			`FPOR_ADDR_TOT2_LIM: rd_d = lim2_q;
			`FPOR_ADDR_STATUS:   rd_d = status;
			`FPOR_ADDR_IRQ_STAT: rd_d = 32'(ist_q);
			`FPOR_ADDR_IRQ_MASK: rd_d = 32'(imsk_q);
			default: begin
				rd_d = 32'h0000_0000;
				rr_d = `FPOR_RESP_DECERR;
			end
			endcase
		end
		// Read clears, but an event in the same cycle survives
		ist_d = ist_q | ev;
		if (do_rd && ara == `FPOR_ADDR_IRQ_STAT) begin
			ist_d = (ist_q & ~ist_q) | ev;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			awa_q <= 8'h00; awh_q <= 1'b0; wd_q <= 32'h0000_0000;
			ws_q <= 4'h0; wh_q <= 1'b0; bv_q <= 1'b0;
			br_q <= `FPOR_RESP_OKAY; rv_q <= 1'b0;
			rr_q <= `FPOR_RESP_OKAY; rd_q <= 32'h0000_0000;
			ctrl_q <= `FPOR_RST_CTRL;
			start_q <= `FPOR_RST_START; units_q <= `FPOR_RST_UNITS;
			ontime_q <= `FPOR_RST_ONTIME; lim1_q <= `FPOR_RST_LIM;
			lim2_q <= `FPOR_RST_LIM; ist_q <= `FPOR_RST_IRQ;
			imsk_q <= `FPOR_RST_IRQ;
		end else if (clk_en) begin
			awa_q <= awa_d; awh_q <= awh_d; wd_q <= wd_d;
			ws_q <= ws_d; wh_q <= wh_d; bv_q <= bv_d; br_q <= br_d;
			rv_q <= rv_d; rr_q <= rr_d; rd_q <= rd_d;
			ctrl_q <= ctrl_d; start_q <= start_d; units_q <= units_d;
			ontime_q <= ontime_d; lim1_q <= lim1_d; lim2_q <= lim2_d;
			ist_q <= ist_d; imsk_q <= imsk_d;
		end
	end

	assign irq = |(ist_q & imsk_q);

	// ----------------------------------------------------------------
	// Pulse engine
	// ----------------------------------------------------------------
	logic                      tick, pen, credit, emit, qfull;
	logic [31:0]               acc_q, acc_d, upp;
	logic [33:0]               sum, rem;
	logic [Q_W-1:0]            q_q, q_d;
	logic [`FPOR_ONTIME_W-1:0] tmr_q, tmr_d, on_ms;
	logic [`FPOR_START_W-1:0]  start_eff;
	fpor_pst_t                 pst_q, pst_d;

	fpor_ms_tick #(
		.CYCLES (MS_CYCLES)
	) u_tick (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.tick    (tick)
	);

	assign pen = ctrl_q[`FPOR_CTRL_EN_BIT];
	// Zero would owe a pulse every tick forever; treat it as one
	assign upp = (units_q == 32'h0000_0000) ? 32'h0000_0001 : units_q;
	assign start_eff = (start_q > `FPOR_START_MAX) ?
	                   `FPOR_START_MAX : start_q;
	assign on_ms = (ontime_q < `FPOR_ONTIME_MIN) ? `FPOR_ONTIME_MIN :
	               (ontime_q > `FPOR_ONTIME_MAX) ? `FPOR_ONTIME_MAX :
	               ontime_q;
	assign qfull = &q_q;
	assign sum = {2'b00, acc_q} + 34'(flow_rate);
	assign rem = sum - {2'b00, upp};
	assign credit = tick && pen && (flow_permille >= start_eff) &&
	                (sum >= {2'b00, upp});
	assign emit = tick && pen && pst_q == FPOR_PST_IDLE &&
	              q_q != '0;

	always_comb begin
		acc_d = acc_q;
		q_d   = q_q;
		tmr_d = tmr_q;
		pst_d = pst_q;
		if (!pen) begin
			acc_d = 32'h0000_0000;
			q_d   = '0;
			pst_d = FPOR_PST_IDLE;
		end else if (tick) begin
			if (flow_permille >= start_eff) begin
				// At most one credit per ms; a surplus waits here
				if (credit) begin
					acc_d = (rem[33:32] != 2'b00) ? `FPOR_ACC_SAT :
					        rem[31:0];
				end else begin
					acc_d = (sum[33:32] != 2'b00) ? `FPOR_ACC_SAT :
					        sum[31:0];
				end
			end
			if (credit && !emit && !qfull) begin
				q_d = q_q + 1'b1;
			end else if (emit && !credit) begin
				q_d = q_q - 1'b1;
			end
			case (pst_q)
			FPOR_PST_IDLE: begin
				if (emit) begin
					pst_d = FPOR_PST_ON;
					tmr_d = on_ms - 1'b1;
				end
			end
			FPOR_PST_ON, FPOR_PST_OFF: begin
				// Gap is on-time plus one ms (the next tick in idle) so downstream sees each edge
				if (tmr_q == '0) begin
					pst_d = (pst_q == FPOR_PST_ON) ?
					        FPOR_PST_OFF : FPOR_PST_IDLE;
					tmr_d = on_ms - 1'b1;
				end else begin
					tmr_d = tmr_q - 1'b1;
				end
			end
			default: pst_d = FPOR_PST_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			acc_q <= 32'h0000_0000;
			q_q   <= '0;
			tmr_q <= '0;
			pst_q <= FPOR_PST_IDLE;
		end else if (clk_en) begin
			acc_q <= acc_d;
			q_q   <= q_d;
			tmr_q <= tmr_d;
			pst_q <= pst_d;
		end
	end

	// ----------------------------------------------------------------
	// Output routing and events
	// ----------------------------------------------------------------
	logic       pulse_on, hit1, hit2, diag_any;
	logic [2:0] prev_q, prev_d;
	logic [1:0] iso_q, iso_d;

	assign pulse_on = (pst_q == FPOR_PST_ON);
	assign hit1 = (tot1_value >= lim1_q);
	assign hit2 = ctrl_q[`FPOR_CTRL_DOWN_BIT] ?
	              (tot2_value == 32'h0000_0000) :
	              (tot2_value >= lim2_q);
	assign diag_any = |diag_events;

	generate
		for (genvar ch = 0; ch < 2; ch++) begin : g_out
			fpor_sel_t sel;
			assign sel = fpor_sel_t'(ctrl_q[`FPOR_CTRL_SEL0_LSB +
			             ch*`FPOR_CTRL_SEL_W +: `FPOR_CTRL_SEL_W]);
			always_comb begin
				case (sel)
				FPOR_SEL_LOW_ALARM:  iso_d[ch] = alarm_low;
				FPOR_SEL_HIGH_ALARM: iso_d[ch] = alarm_high;
				FPOR_SEL_IN_BAND:    iso_d[ch] = ~alarm_low &
				                                 ~alarm_high;
				FPOR_SEL_TOT1:       iso_d[ch] = hit1;
				FPOR_SEL_TOT2:       iso_d[ch] = hit2;
				FPOR_SEL_PULSE:      iso_d[ch] = pulse_on;
				FPOR_SEL_DIAG:       iso_d[ch] = diag_any;
				FPOR_SEL_MANUAL:     iso_d[ch] = 1'b1;
				default:             iso_d[ch] = 1'b0;
				endcase
			end
		end
	endgenerate

	always_comb begin
		prev_d = {diag_any, hit2, hit1};
		ev = '0;
		ev[`FPOR_IRQ_EMIT] = emit;
		ev[`FPOR_IRQ_QSAT] = credit & qfull & ~emit;
		ev[`FPOR_IRQ_TOT1] = hit1 & ~prev_q[0];
		ev[`FPOR_IRQ_TOT2] = hit2 & ~prev_q[1];
		ev[`FPOR_IRQ_DIAG] = diag_any & ~prev_q[2];
		status = 32'h0000_0000;
		status[Q_W-1:0] = q_q;
		status[`FPOR_STAT_PULSE_BIT] = pulse_on;
		status[`FPOR_STAT_OUT_LSB +: 2] = iso_q;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			prev_q <= 3'h0;
			iso_q  <= 2'h0;
		end else if (clk_en) begin
			prev_q <= prev_d;
			iso_q  <= iso_d;
		end
	end

	assign iso_out = iso_q;
endmodule

// ==== common/fpor_defines.svh ====
/*
 * Offsets, field positions, reset values and timing figures of the
 * flow pulse and output router.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef FPOR_DEFINES_SVH
`define FPOR_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FPOR_ADDR_CTRL      8'h00
`define FPOR_ADDR_START     8'h04
`define FPOR_ADDR_UNITS     8'h08
`define FPOR_ADDR_ONTIME    8'h0c
`define FPOR_ADDR_TOT1_LIM  8'h10
`define FPOR_ADDR_TOT2_LIM  8'h14
`define FPOR_ADDR_STATUS    8'h18
`define FPOR_ADDR_IRQ_STAT  8'h1c
`define FPOR_ADDR_IRQ_MASK  8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FPOR_CTRL_EN_BIT    0
`define FPOR_CTRL_SEL0_LSB  4
`define FPOR_CTRL_SEL1_LSB  8
`define FPOR_CTRL_SEL_W     4
`define FPOR_CTRL_DOWN_BIT  12
`define FPOR_START_W        10
`define FPOR_ONTIME_W       16
`define FPOR_STAT_PULSE_BIT 16
`define FPOR_STAT_OUT_LSB   17
`define FPOR_IRQ_N          5
`define FPOR_IRQ_EMIT       0
`define FPOR_IRQ_QSAT       1
`define FPOR_IRQ_TOT1       2
`define FPOR_IRQ_TOT2       3
`define FPOR_IRQ_DIAG       4

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define FPOR_RST_CTRL       32'h0000_0000
`define FPOR_RST_START      10'h000
`define FPOR_RST_UNITS      32'h0000_0001
`define FPOR_RST_ONTIME     16'h000a
`define FPOR_RST_LIM        32'h0000_0000
`define FPOR_RST_IRQ        5'h00
`define FPOR_START_MAX      10'h3e8
`define FPOR_ONTIME_MIN     16'h000a
`define FPOR_ONTIME_MAX     16'h1999
`define FPOR_ACC_SAT        32'hffff_ffff

// ----------------------------------------------------------------
// Bus answers and timing
// ----------------------------------------------------------------
`define FPOR_RESP_OKAY      2'b00
`define FPOR_RESP_DECERR    2'b11
`define FPOR_CLK_NS         10
`define FPOR_MS_NS          1000000

`endif

// ==== common/fpor_pkg.sv ====
/*
 * Types of the flow pulse and output router.
 * Assumes fpor_defines.svh is on the include path.
 */
`include "fpor_defines.svh"

package fpor_pkg;

	// Output action selector, in register encoding order
	typedef enum logic [`FPOR_CTRL_SEL_W-1:0] {
		FPOR_SEL_DISABLED,
		FPOR_SEL_LOW_ALARM,
		FPOR_SEL_HIGH_ALARM,
		FPOR_SEL_IN_BAND,
		FPOR_SEL_TOT1,
		FPOR_SEL_TOT2,
		FPOR_SEL_PULSE,
		FPOR_SEL_DIAG,
		FPOR_SEL_MANUAL
	} fpor_sel_t;

	// Pulse emitter states
	typedef enum logic [1:0] {
		FPOR_PST_IDLE,
		FPOR_PST_ON,
		FPOR_PST_OFF
	} fpor_pst_t;

endpackage

// ==== verilog/fpor_ms_tick.sv ====
/*
 * Millisecond time base: one-cycle tick every CYCLES enabled clocks.
 * Assumes a free-running sys_clk; clk_en low freezes the count.
 */
`timescale 1ns/1ps
`include "fpor_defines.svh"

module fpor_ms_tick #(
	parameter int CYCLES = `FPOR_MS_NS / `FPOR_CLK_NS
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic reset_n,
	input  wire logic clk_en,
	// Time base
	output logic      tick
);
	import fpor_pkg::*;

	localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	generate
		if (CYCLES < 2) begin : g_bad
			$error("fpor_ms_tick: CYCLES must be at least 2");
		end
	endgenerate

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic          tick_q;
	logic          tick_d;

	always_comb begin
		cnt_d  = cnt_q;
		tick_d = 1'b0;
		if (clk_en) begin
			if (cnt_q == LAST) begin
				cnt_d  = '0;
				tick_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else if (clk_en) begin
			// A pending tick must survive a pause of the clock enable
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q & clk_en;
endmodule

// ==== dv/fpor_load.sv ====
/*
 * Model of the equipment on one isolated output: counts pulses and keeps
 * the length of the last one.
 * Assumes the output is sampled on the block's own clock.
 */
`timescale 1ns/1ps
module fpor_load (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic reset_n,
	// Isolated output
	input  wire logic iso,
	// Observations
	output int        rises,
	output int        width
);
	int run;

	// A closed contact draws no current, so only high time is counted
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rises <= 0;
			width <= 0;
			run <= 0;
		end else if (iso) begin
			run <= run + 1;
			if (run == 0)
				rises <= rises + 1;
		end else begin
			if (run != 0)
				width <= run;
			run <= 0;
		end
	end
endmodule

// ==== dv/fpor_top_sva.sv ====
/*
 * Checker of fpor_top: bus handshakes, clock enable and output selectors.
 * Assumes it is bound to every fpor_top by the statement at the foot.
 */
`timescale 1ns/1ps
module fpor_top_sva (
	// Clock and control
	input wire logic        sys_clk,
	input wire logic        reset_n,
	input wire logic        clk_en,
	// Bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Outputs
	input wire logic [1:0]  iso_out,
	input wire logic        irq
);
	logic cfg_q;
	logic cfg_d;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	// No write seen yet means both selectors still hold their reset code
	always_comb cfg_d = cfg_q | s_axi_bvalid;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			cfg_q <= 1'b0;
		else
			cfg_q <= cfg_d;
	end

	sel_reset_a: assert property (!cfg_q |-> iso_out == 2'b00)
		else $error("output energized before configuration");
	frozen_out_a: assert property (!clk_en |=> $stable(iso_out) && $stable(irq))
		else $error("outputs moved while clock enable low");
	idle_ready_a: assert property (!clk_en |->
		!s_axi_awready && !s_axi_wready && !s_axi_arready)
		else $error("ready offered while clock enable low");
	wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken with response pending");
	rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken with data pending");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data dropped early");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	// Both halves are parked for one cycle before the response rises
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");

	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property ($rose(iso_out[1]));
	cover property ($rose(irq));
endmodule

bind fpor_top fpor_top_sva u_sva (
	.sys_clk, .reset_n, .clk_en, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .iso_out, .irq);

// ==== dv/flow_pulse_and_output_router_bench.sv ====
/*
 * Self-checking bench of fpor_top: register map, output routing, pulse
 * queue and interrupt.
 * Assumes fpor_pkg, fpor_top, fpor_load and the checker are compiled.
 */
`timescale 1ns/1ps
`include "fpor_defines.svh"
module flow_pulse_and_output_router_bench;
	import fpor_pkg::*;
	localparam int         MSC = 20;
	localparam logic [1:0] OK  = `FPOR_RESP_OKAY;
	logic        sys_clk, reset_n, clk_en, awvalid, wvalid, bready;
	logic        arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic        alo, ahi, irq;
	logic [7:0]  awaddr, araddr, diag;
	logic [31:0] wdata, rdata, tot1, tot2, lim1, lim2, m;
	logic [15:0] flow;
	logic [9:0]  pml;
	logic [1:0]  bresp, rresp, iso;
	logic [31:0] rq[$], mq[$];
	logic [1:0]  bq[$], sq[$];
	int          bad_count, checked, cyc, r0, r1, w0, w1, n0, n1;

	fpor_top #(.Q_W(2), .MS_CYCLES(MSC)) uut (
		.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .flow_rate(flow),
		.flow_permille(pml), .alarm_low(alo), .alarm_high(ahi),
		.tot1_value(tot1), .tot2_value(tot2), .diag_events(diag),
		.iso_out(iso), .irq(irq));
	fpor_load ld0 (.sys_clk(sys_clk), .reset_n(reset_n), .iso(iso[0]),
		.rises(r0), .width(w0));
	fpor_load ld1 (.sys_clk(sys_clk), .reset_n(reset_n), .iso(iso[1]),
		.rises(r1), .width(w1));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ----------------------------------------------------------------
	// Checking and closing
	// ----------------------------------------------------------------
	task cmp(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task conclude;
		if (bad_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	function automatic logic route(input int s);
		case (s)
			1: route = alo;
			2: route = ahi;
			3: route = !alo && !ahi;
			4: route = tot1 >= lim1;
			5: route = tot2 >= lim2;
			7: route = |diag;
			8: route = 1'b1;
			default: route = 1'b0;
		endcase
	endfunction

	// Results are paired with the oldest note as they appear on the bus
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			conclude();
		end
		if (bvalid && bready)
			cmp(32'(bresp), 32'(bq.pop_front()));
		if (rvalid && rready) begin
			m = mq.pop_front();
			cmp(rdata & m, rq.pop_front() & m);
			cmp(32'(rresp), 32'(sq.pop_front()));
		end
	end

	// ----------------------------------------------------------------
	// Bus master
	// ----------------------------------------------------------------
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		bit ta;
		bit tw;
		bq.push_back(r);
		ta = 1'b0;
		tw = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge sys_clk);
			if (awvalid && awready) begin
				ta = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				tw = 1'b1;
				wvalid <= 1'b0;
			end
		end
		// Late ready stalls the response on purpose
		repeat ($urandom_range(2)) @(posedge sys_clk);
		bready <= 1'b1;
		do @(posedge sys_clk); while (!bvalid);
		bready <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k,
		input logic [1:0] r);
		rq.push_back(e);
		mq.push_back(k);
		sq.push_back(r);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge sys_clk); while (!arready);
		arvalid <= 1'b0;
		repeat ($urandom_range(2)) @(posedge sys_clk);
		rready <= 1'b1;
		do @(posedge sys_clk); while (!rvalid);
		rready <= 1'b0;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, alo, ahi, reset_n} = '0;
		{awaddr, araddr, wdata, tot1, tot2, flow, pml, diag} = '0;
		clk_en = 1'b1;
		void'($urandom(32'h5ac2ad2d));
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		rd(`FPOR_ADDR_CTRL, 32'h0, '1, OK);
		rd(`FPOR_ADDR_START, 32'h0, '1, OK);
		rd(`FPOR_ADDR_UNITS, 32'h1, '1, OK);
		rd(`FPOR_ADDR_ONTIME, 32'ha, '1, OK);
		rd(8'h24, 32'h0, '1, `FPOR_RESP_DECERR);
		wr(8'h24, 32'h5, `FPOR_RESP_DECERR);
		lim1 = $urandom();
		lim2 = $urandom();
		wr(`FPOR_ADDR_TOT1_LIM, lim1, OK);
		wr(`FPOR_ADDR_TOT2_LIM, lim2, OK);
		for (int s = 0; s < 9; s++) begin
			tot1 <= lim1 - 32'($urandom_range(1));
			tot2 <= lim2 - 32'($urandom_range(1));
			{alo, ahi} <= 2'($urandom());
			diag <= 8'($urandom()) & 8'h81;
			wr(`FPOR_ADDR_CTRL, 32'((8 - s) << 8 | s << 4), OK);
			repeat (2) @(posedge sys_clk);
			cmp(32'(iso), 32'({route(8 - s), route(s)}));
		end
		wr(`FPOR_ADDR_CTRL, 32'h1050, OK);
		tot2 <= 32'h0;
		repeat (2) @(posedge sys_clk);
		cmp(32'(iso[0]), 32'h1);
		clk_en <= 1'b0;
		repeat (3) @(posedge sys_clk);
		clk_en <= 1'b1;
		// Pulse queue: on-time below range is lifted to its minimum
		cmp(32'(irq), 32'h0);
		wr(`FPOR_ADDR_UNITS, 32'd100, OK);
		wr(`FPOR_ADDR_ONTIME, 32'd3, OK);
		wr(`FPOR_ADDR_START, 32'd500, OK);
		wr(`FPOR_ADDR_IRQ_MASK, 32'h2, OK);
		rd(`FPOR_ADDR_IRQ_STAT, 32'h0, 32'h3, OK);
		n0 = r0;
		n1 = r1;
		flow <= 16'd100;
		pml <= 10'd499;
		wr(`FPOR_ADDR_CTRL, 32'h0601, OK);
		repeat (10 * MSC) @(posedge sys_clk);
		rd(`FPOR_ADDR_STATUS, 32'h0, 32'h3, OK);
		cmp(32'(r1 - n1), 32'h0);
		pml <= 10'd500;
		repeat (8 * MSC) @(posedge sys_clk);
		rd(`FPOR_ADDR_STATUS, 32'h3, 32'h3, OK);
		flow <= 16'h0;
		n1 = r1;
		repeat (90 * MSC) @(posedge sys_clk);
		cmp(32'(r1 - n1), 32'h3);
		cmp(32'(w1), 32'(10 * MSC));
		cmp(32'(r0 - n0), 32'h0);
		rd(`FPOR_ADDR_STATUS, 32'h0, 32'h3, OK);
		cmp(32'(irq), 32'h1);
		rd(`FPOR_ADDR_IRQ_STAT, 32'h3, 32'h3, OK);
		cmp(32'(irq), 32'h0);
		flow <= 16'd100;
		repeat (5 * MSC) @(posedge sys_clk);
		wr(`FPOR_ADDR_CTRL, 32'h0600, OK);
		rd(`FPOR_ADDR_STATUS, 32'h0, 32'h3, OK);
		cmp(32'(iso[1]), 32'h0);
		conclude();
	end
endmodule
